//--- pkg/pm_pins_consts.vh
/*
  constants for the power-management pin block: function-select bit positions,
  timing figures and reset values.
  assumes a 200 MHz core clock and a single synchronous active-low reset.
*/
`ifndef PM_PINS_CONSTS_VH
`define PM_PINS_CONSTS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_FREQ_HZ 200000000
`define CONTRAST_FREQ_HZ 1000
// counts for the 200 MHz clock: 1 kHz period, last count of the 2 Hz and 1 Hz half periods
`define CONTRAST_PERIOD_CYC 18'h30d40
`define CONTRAST_LAST 18'h30d3f
`define SQW_2HZ_LAST 28'h2faf07f
`define SQW_1HZ_LAST 28'h5f5e0ff
`define BACKLIGHT_PERIOD_CYC 18'h30d40
`define CNT_W 28
`define CONTRAST_CNT_W 18
`define DUTY_W 8
`define DUTY_FULL 8'hff

// ----------------------------------------
// output function-select bit positions (1 = dedicated function)
// ----------------------------------------
`define OSEL_W 12
`define OSEL_BUS_CLK_HALT 0
`define OSEL_SLOW 1
`define OSEL_APM 2
`define OSEL_SQW 3
`define OSEL_PWR0 4
`define OSEL_PWR1 5
`define OSEL_PWR2 6
`define OSEL_BACKLIGHT 7
`define OSEL_DISPLAY 8
`define OSEL_CONTRAST 9
`define OSEL_IN_STROBE 10
`define OSEL_OUT_STROBE 11

// ----------------------------------------
// input function-select bit positions (1 = dedicated function)
// ----------------------------------------
`define ISEL_W 14
`define ISEL_BUS_REQ 0
`define ISEL_FORCE_SUSP 1
`define ISEL_EXT_SW 2
`define ISEL_THERMAL 3
`define ISEL_AC 4
`define ISEL_SETUP 5
`define ISEL_EJECT 6
`define ISEL_DOCK 7
`define ISEL_HOTKEY 8
`define ISEL_GRAPHICS 9
`define ISEL_VEE 10
`define ISEL_BATT_FIRST 11
`define ISEL_BATT_LAST 12
`define ISEL_USB_OC 13

// ----------------------------------------
// event bit positions in the event pulse vector
// ----------------------------------------
`define EV_W 12
`define EV_BUS_REQ 0
`define EV_EXT_SW 1
`define EV_THERMAL 2
`define EV_AC 3
`define EV_SETUP 4
`define EV_EJECT 5
`define EV_DOCK 6
`define EV_HOTKEY 7
`define EV_GRAPHICS 8
`define EV_BATT_FIRST 9
`define EV_BATT_LAST 10
`define EV_USB_OC 11

// ----------------------------------------
// reset values, strobe length and strap counter steps
// ----------------------------------------
`define GPO_RESET 12'h000
`define OSEL_RESET 12'h000
`define ISEL_RESET 14'h0000
`define STROBE_LEN 4'h4
`define STRAP_TAKE 2'h2
`define STRAP_DONE 2'h3

`endif

//--- verilog/pm_pin_signals_and_events.v
/*
  power-management pin block: dedicated-function or general-purpose muxing of the
  clock/power control outputs, waveform generators for square wave, backlight and
  contrast, event detection on the external inputs, and extended gpio pins.
  assumes all pin inputs are asynchronous to clk; the suspend/apm/power-removal sources are
  decided by the surrounding power-management logic and arrive as plain ports.
*/
`timescale 1ns/1ps
`include "pm_pins_consts.vh"

module pm_pin_signals_and_events
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // configuration
  input wire [`OSEL_W-1:0] out_func_sel,
  input wire [`ISEL_W-1:0] in_func_sel,
  input wire [`OSEL_W-1:0] general_output,
  input wire sqw_select_1hz,
  input wire backlight_wave_en,
  input wire [`DUTY_W-1:0] backlight_duty,
  input wire [`DUTY_W-1:0] contrast_duty,
  input wire display_invert,
  input wire [11:0] gpio_dir_out,
  input wire [11:0] gpio_out_val,
  input wire [3:0] battery_select_val,
  input wire battery_select_en,
  input wire in_strobe_req,
  input wire out_strobe_req,
  // power-management state from the surrounding logic
  input wire bus_clock_stop_req,
  input wire suspend_active,
  input wire slow_req,
  input wire halt_cycle,
  input wire stop_grant_cycle,
  input wire [2:0] power_remove_req,
  input wire vga_timer_mode,
  // external pins
  input wire bus_request_event_n,
  input wire force_suspend_in,
  input wire external_switch_event,
  input wire thermal_event_n,
  input wire ac_adapter_present,
  input wire setup_switch_n,
  input wire eject_in,
  input wire dock_insert_n,
  input wire hot_key_event_n,
  input wire graphics_activity_n,
  input wire panel_backlight_vee_in,
  input wire battery_low_first_n,
  input wire battery_low_last_n,
  input wire [1:0] usb_overcurrent_n,
  input wire [11:0] gpio_in,
  // control outputs
  output reg bus_clock_halt_n,
  output reg suspend_status_to_northbridge_n,
  output reg clockgen_slow_request,
  output reg apm_state_indicator_n,
  output reg square_wave_out,
  output reg clockgen_power_remove_n,
  output reg power_remove_keep_dram,
  output reg power_remove_keep_suspend,
  output reg backlight_wave_out,
  output reg display_on_out,
  output reg contrast_out,
  output reg ext_input_latch_strobe_n,
  output reg ext_output_latch_strobe,
  // gpio pins 19:8 as output and enable
  output reg [11:0] gpio_out,
  output reg [11:0] gpio_oe,
  // status
  output reg [`EV_W-1:0] event_pulse,
  output reg [`ISEL_W-1:0] general_input,
  output reg force_suspend_req,
  output reg vga_timer_reload,
  output reg [3:0] suspend_resume_event,
  output reg [3:0] standby_wake_event,
  output reg atx_supply
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
localparam SYNC_W = 28;
wire [SYNC_W-1:0] raw_in;
reg [SYNC_W-1:0] sync1;
reg [SYNC_W-1:0] sync2;
reg [SYNC_W-1:0] sync3;
reg [1:0] strap_wait;

assign raw_in = {gpio_in, usb_overcurrent_n, battery_low_last_n, battery_low_first_n,
  panel_backlight_vee_in, graphics_activity_n, hot_key_event_n, dock_insert_n,
  eject_in, setup_switch_n, ac_adapter_present, thermal_event_n,
  external_switch_event, force_suspend_in, bus_request_event_n};

always @(posedge clk)
begin
  if (!resetn)
  begin
    sync1 <= {SYNC_W{1'b1}};
    sync2 <= {SYNC_W{1'b1}};
    sync3 <= {SYNC_W{1'b1}};
  end
  else
  begin
    sync1 <= raw_in;
    sync2 <= sync1;
    sync3 <= sync2;
  end
end

// synchronised levels, sync3 holds the previous value for edge finding
wire s_busreq_n = sync2[0];
wire s_force = sync2[1];
wire s_external_switch_event = sync2[2];
wire s_therm_n = sync2[3];
wire s_ac = sync2[4];
wire s_setup_n = sync2[5];
wire s_eject = sync2[6];
wire s_dock_n = sync2[7];
wire s_hot_n = sync2[8];
wire s_gfx_n = sync2[9];
wire s_vee = sync2[10];
wire s_bl1_n = sync2[11];
wire s_bl2_n = sync2[12];
wire [1:0] s_oc_n = sync2[14:13];
wire [11:0] s_gpio = sync2[26:15];
wire [11:0] p_gpio = sync3[26:15];

// asserted-edge finder: fall for low-active inputs, rise for high-active
function edge_on;
  input cur;
  input prev;
  input active_low;
  begin
    edge_on = active_low ? (prev & ~cur) : (cur & ~prev);
  end
endfunction

// ----------------------------------------
// event detection
// ----------------------------------------
reg [`EV_W-1:0] next_event;
always @*
begin
  next_event = {`EV_W{1'b0}};
  next_event[`EV_BUS_REQ] = in_func_sel[`ISEL_BUS_REQ] & edge_on(s_busreq_n, sync3[0], 1'b1);
  next_event[`EV_EXT_SW] = in_func_sel[`ISEL_EXT_SW] & edge_on(s_external_switch_event, sync3[2], 1'b0);
  next_event[`EV_THERMAL] = in_func_sel[`ISEL_THERMAL] & edge_on(s_therm_n, sync3[3], 1'b1);
  next_event[`EV_AC] = in_func_sel[`ISEL_AC] & (s_ac ^ sync3[4]);
  next_event[`EV_SETUP] = in_func_sel[`ISEL_SETUP] & edge_on(s_setup_n, sync3[5], 1'b1);
  next_event[`EV_EJECT] = in_func_sel[`ISEL_EJECT] & edge_on(s_eject, sync3[6], 1'b0);
  next_event[`EV_DOCK] = in_func_sel[`ISEL_DOCK] & edge_on(s_dock_n, sync3[7], 1'b1);
  next_event[`EV_HOTKEY] = in_func_sel[`ISEL_HOTKEY] & edge_on(s_hot_n, sync3[8], 1'b1);
  next_event[`EV_GRAPHICS] = in_func_sel[`ISEL_GRAPHICS] & ~vga_timer_mode
    & edge_on(s_gfx_n, sync3[9], 1'b1);
  next_event[`EV_BATT_FIRST] = in_func_sel[`ISEL_BATT_FIRST]
    & edge_on(s_bl1_n, sync3[11], 1'b1);
  next_event[`EV_BATT_LAST] = in_func_sel[`ISEL_BATT_LAST]
    & edge_on(s_bl2_n, sync3[12], 1'b1);
  next_event[`EV_USB_OC] = in_func_sel[`ISEL_USB_OC]
    & (edge_on(s_oc_n[0], sync3[13], 1'b1) | edge_on(s_oc_n[1], sync3[14], 1'b1));
end

// gpio input edges: 19:16 resume from suspend, 11:8 wake from standby
wire [11:0] gpio_edge;
genvar gi;
generate
  for (gi = 0; gi < 12; gi = gi + 1)
  begin : g_edge
    assign gpio_edge[gi] = ~gpio_dir_out[gi] & (s_gpio[gi] ^ p_gpio[gi]);
  end
endgenerate

always @(posedge clk)
begin
  if (!resetn)
  begin
    event_pulse <= {`EV_W{1'b0}};
    general_input <= {`ISEL_W{1'b0}};
    force_suspend_req <= 1'b0;
    vga_timer_reload <= 1'b0;
    suspend_resume_event <= 4'h0;
    standby_wake_event <= 4'h0;
  end
  else
  begin
    event_pulse <= next_event & {`EV_W{strap_wait == `STRAP_DONE}}; // hold off preset edges
    // general input bits read the pin level when the pin is not in its dedicated use
    general_input <= ~in_func_sel & {s_oc_n[0], s_bl2_n, s_bl1_n, s_vee, s_gfx_n, s_hot_n,
      s_dock_n, s_eject, s_setup_n, s_ac, s_therm_n, s_external_switch_event, s_force, s_busreq_n};
    force_suspend_req <= in_func_sel[`ISEL_FORCE_SUSP] & s_force;
    vga_timer_reload <= in_func_sel[`ISEL_GRAPHICS] & vga_timer_mode & ~s_gfx_n;
    suspend_resume_event <= gpio_edge[11:8] & {4{strap_wait == `STRAP_DONE}};
    standby_wake_event <= gpio_edge[3:0] & {4{strap_wait == `STRAP_DONE}};
  end
end

// ----------------------------------------
// power supply strap, taken once the synchronisers hold real pin levels
// ----------------------------------------
always @(posedge clk)
begin
  if (!resetn)
  begin
    strap_wait <= 2'h0;
    atx_supply <= 1'b0;
  end
  else if (strap_wait != `STRAP_DONE)
  begin
    strap_wait <= strap_wait + 2'h1;
    if (strap_wait == `STRAP_TAKE)
      atx_supply <= ~s_gpio[5];
  end
end

// ----------------------------------------
// square wave divider
// ----------------------------------------
reg [`CNT_W-1:0] sqw_cnt;
reg sqw_level;
wire [`CNT_W-1:0] sqw_last = sqw_select_1hz ? `SQW_1HZ_LAST : `SQW_2HZ_LAST;

always @(posedge clk)
begin
  if (!resetn)
  begin
    sqw_cnt <= {`CNT_W{1'b0}};
    sqw_level <= 1'b0;
  end
  else if (sqw_cnt >= sqw_last)
  begin
    sqw_cnt <= {`CNT_W{1'b0}};
    sqw_level <= ~sqw_level;
  end
  else
    sqw_cnt <= sqw_cnt + 1'b1;
end

// ----------------------------------------
// 1 kHz period counter shared by contrast and backlight
// ----------------------------------------
reg [`CONTRAST_CNT_W-1:0] pwm_cnt;
wire [`CONTRAST_CNT_W+`DUTY_W-1:0] contrast_thr;
wire [`CONTRAST_CNT_W+`DUTY_W-1:0] backlight_thr;
assign contrast_thr = contrast_duty * `CONTRAST_PERIOD_CYC / `DUTY_FULL;
assign backlight_thr = backlight_duty * `BACKLIGHT_PERIOD_CYC / `DUTY_FULL;

always @(posedge clk)
begin
  if (!resetn)
    pwm_cnt <= {`CONTRAST_CNT_W{1'b0}};
  else if (pwm_cnt == `CONTRAST_LAST)
    pwm_cnt <= {`CONTRAST_CNT_W{1'b0}};
  else
    pwm_cnt <= pwm_cnt + 1'b1;
end

// ----------------------------------------
// latch strobes
// ----------------------------------------
reg [3:0] in_strobe_cnt;
reg [3:0] out_strobe_cnt;
always @(posedge clk)
begin
  if (!resetn)
  begin
    in_strobe_cnt <= 4'h0;
    out_strobe_cnt <= 4'h0;
  end
  else
  begin
    if (in_strobe_req)
      in_strobe_cnt <= `STROBE_LEN;
    else if (in_strobe_cnt != 4'h0)
      in_strobe_cnt <= in_strobe_cnt - 4'h1;
    if (out_strobe_req)
      out_strobe_cnt <= `STROBE_LEN;
    else if (out_strobe_cnt != 4'h0)
      out_strobe_cnt <= out_strobe_cnt - 4'h1;
  end
end

// ----------------------------------------
// output muxing
// ----------------------------------------
always @(posedge clk)
begin
  if (!resetn)
  begin
    bus_clock_halt_n <= 1'b1;
    suspend_status_to_northbridge_n <= 1'b1;
    clockgen_slow_request <= 1'b0;
    apm_state_indicator_n <= 1'b1;
    square_wave_out <= 1'b0;
    clockgen_power_remove_n <= 1'b1;
    power_remove_keep_dram <= 1'b0;
    power_remove_keep_suspend <= 1'b0;
    backlight_wave_out <= 1'b0;
    display_on_out <= 1'b0;
    contrast_out <= 1'b0;
    ext_input_latch_strobe_n <= 1'b1;
    ext_output_latch_strobe <= 1'b0;
    gpio_out <= 12'h000;
    gpio_oe <= 12'h000;
  end
  else
  begin
    bus_clock_halt_n <= out_func_sel[`OSEL_BUS_CLK_HALT] ? ~bus_clock_stop_req
      : general_output[`OSEL_BUS_CLK_HALT];
    suspend_status_to_northbridge_n <= ~suspend_active;
    clockgen_slow_request <= out_func_sel[`OSEL_SLOW] ? slow_req
      : general_output[`OSEL_SLOW];
    apm_state_indicator_n <= out_func_sel[`OSEL_APM] ? ~(halt_cycle | stop_grant_cycle)
      : general_output[`OSEL_APM];
    square_wave_out <= out_func_sel[`OSEL_SQW] ? sqw_level : general_output[`OSEL_SQW];
    clockgen_power_remove_n <= out_func_sel[`OSEL_PWR0] ? ~power_remove_req[0]
      : general_output[`OSEL_PWR0];
    power_remove_keep_dram <= out_func_sel[`OSEL_PWR1] ? power_remove_req[1]
      : general_output[`OSEL_PWR1];
    power_remove_keep_suspend <= out_func_sel[`OSEL_PWR2] ? power_remove_req[2]
      : general_output[`OSEL_PWR2];
    backlight_wave_out <= out_func_sel[`OSEL_BACKLIGHT]
      ? (backlight_wave_en & s_vee & (pwm_cnt < backlight_thr))
      : general_output[`OSEL_BACKLIGHT];
    display_on_out <= out_func_sel[`OSEL_DISPLAY] ? (s_vee ^ display_invert)
      : general_output[`OSEL_DISPLAY];
    contrast_out <= out_func_sel[`OSEL_CONTRAST] ? (pwm_cnt < contrast_thr)
      : general_output[`OSEL_CONTRAST];
    ext_input_latch_strobe_n <= out_func_sel[`OSEL_IN_STROBE] ? (in_strobe_cnt == 4'h0)
      : general_output[`OSEL_IN_STROBE];
    ext_output_latch_strobe <= out_func_sel[`OSEL_OUT_STROBE] ? (out_strobe_cnt != 4'h0)
      : general_output[`OSEL_OUT_STROBE];
    // gpio 15:12 carry battery select when enabled
    gpio_out <= battery_select_en ? {gpio_out_val[11:8], battery_select_val, gpio_out_val[3:0]}
      : gpio_out_val;
    gpio_oe <= battery_select_en ? {gpio_dir_out[11:8], 4'hf, gpio_dir_out[3:0]}
      : gpio_dir_out;
  end
end

endmodule

//--- verification/pm_pins_chk_asserts.sv
/*
  checker for the power-management pin block: timing and muxing of its outputs.
  assumes one clock domain, bound to the block's own ports by name.
*/
`timescale 1ns/1ps
`include "pm_pins_consts.vh"
module pm_pins_chk
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // watched inputs
  input wire [`OSEL_W-1:0] out_func_sel,
  input wire [`ISEL_W-1:0] in_func_sel,
  input wire [`OSEL_W-1:0] general_output,
  input wire [3:0] battery_select_val,
  input wire battery_select_en,
  input wire bus_clock_stop_req,
  input wire suspend_active,
  input wire halt_cycle,
  input wire stop_grant_cycle,
  input wire [2:0] power_remove_req,
  input wire setup_switch_n,
  input wire ac_adapter_present,
  // watched outputs
  input wire bus_clock_halt_n,
  input wire suspend_status_to_northbridge_n,
  input wire apm_state_indicator_n,
  input wire power_remove_keep_dram,
  input wire ext_input_latch_strobe_n,
  input wire [11:0] gpio_out,
  input wire [11:0] gpio_oe,
  input wire [`EV_W-1:0] event_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_halt;
    $past(resetn) |-> bus_clock_halt_n == ($past(out_func_sel[`OSEL_BUS_CLK_HALT]) ?
      !$past(bus_clock_stop_req) : $past(general_output[`OSEL_BUS_CLK_HALT]));
  endproperty
  a_halt: assert property (p_halt) else $error("bus clock halt pin wrong");
  property p_susp;
    $past(resetn) |-> suspend_status_to_northbridge_n == !$past(suspend_active);
  endproperty
  a_susp: assert property (p_susp) else $error("suspend status pin wrong");
  property p_apm;
    out_func_sel[`OSEL_APM] && (halt_cycle || stop_grant_cycle) |=> !apm_state_indicator_n;
  endproperty
  a_apm: assert property (p_apm) else $error("apm indicator not asserted");
  property p_pwr;
    $past(resetn) |-> power_remove_keep_dram == ($past(out_func_sel[`OSEL_PWR1]) ?
      $past(power_remove_req[1]) : $past(general_output[`OSEL_PWR1]));
  endproperty
  a_pwr: assert property (p_pwr) else $error("power removal pin wrong");
  property p_strb;
    $fell(ext_input_latch_strobe_n) && out_func_sel[`OSEL_IN_STROBE] |->
      !ext_input_latch_strobe_n [*4] ##1 ext_input_latch_strobe_n;
  endproperty
  a_strb: assert property (p_strb) else $error("input latch strobe length wrong");
  property p_setup;
    in_func_sel[`ISEL_SETUP] && $fell(setup_switch_n) |-> ##3 event_pulse[`EV_SETUP];
  endproperty
  a_setup: assert property (p_setup) else $error("setup event missing");
  property p_ac;
    in_func_sel[`ISEL_AC] && $changed(ac_adapter_present) |-> ##3 event_pulse[`EV_AC];
  endproperty
  a_ac: assert property (p_ac) else $error("ac adapter event missing");
  property p_batsel;
    $past(resetn) && $past(battery_select_en) |->
      gpio_oe[7:4] == 4'hf && gpio_out[7:4] == $past(battery_select_val);
  endproperty
  a_batsel: assert property (p_batsel) else $error("battery select drive wrong");
endmodule

//--- verification/pm_pins_far_side.sv
/*
  far-side model: event sources, panel supply, board strap and gpio pads.
  assumes the bench calls flip from its own sequence; pads resolve device drive.
*/
`timescale 1ns/1ps
module pm_pins_far_side
(
  // clock
  input wire clk,
  // device gpio drive
  input wire [11:0] gpio_out,
  input wire [11:0] gpio_oe,
  // pins toward the device
  output wire bus_request_event_n,
  output wire force_suspend_in,
  output wire external_switch_event,
  output wire thermal_event_n,
  output wire ac_adapter_present,
  output wire setup_switch_n,
  output wire eject_in,
  output wire dock_insert_n,
  output wire hot_key_event_n,
  output wire graphics_activity_n,
  output wire panel_backlight_vee_in,
  output wire battery_low_first_n,
  output wire battery_low_last_n,
  output wire [1:0] usb_overcurrent_n,
  output wire [11:0] gpio_in
);
  // bits 14:0 single pins, 26:15 pad drive; gpio13 strapped low for atx
  logic [26:0] lvl = {12'hfdf, 15'h7ba9};
  // request and activity lines idle high, driven low while active
  assign {usb_overcurrent_n, battery_low_last_n, battery_low_first_n, panel_backlight_vee_in,
    graphics_activity_n, hot_key_event_n, dock_insert_n, eject_in, setup_switch_n,
    ac_adapter_present, thermal_event_n, external_switch_event, force_suspend_in,
    bus_request_event_n} = lvl[14:0];
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & lvl[26:15]);
  task automatic flip(input int idx);
    @(posedge clk);
    lvl[idx] <= ~lvl[idx];
  endtask
endmodule

//--- verification/pm_pin_signals_and_events_test.sv
/*
  testbench for the power-management pin block with its far-side model.
  assumes a 200 MHz clock and the checker bound below.
*/
`timescale 1ns/1ps
`include "pm_pins_consts.vh"
module pm_pin_signals_and_events_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [11:0] out_func_sel = 12'h000;
  reg [11:0] general_output = 12'h000;
  reg [11:0] gpio_dir_out = 12'h000;
  reg [11:0] gpio_out_val = 12'h3c5;
  reg [13:0] in_func_sel = 14'h0000;
  reg [7:0] backlight_duty = 8'hff;
  reg [7:0] contrast_duty = 8'h00;
  reg [3:0] battery_select_val = 4'ha;
  reg [2:0] power_remove_req = 3'h0;
  reg sqw_select_1hz = 1'b1, backlight_wave_en = 1'b0, display_invert = 1'b0;
  reg battery_select_en = 1'b0, in_strobe_req = 1'b0, out_strobe_req = 1'b0;
  reg bus_clock_stop_req = 1'b0, suspend_active = 1'b0, slow_req = 1'b0;
  reg halt_cycle = 1'b0, stop_grant_cycle = 1'b0, vga_timer_mode = 1'b0;
  wire bus_request_event_n, force_suspend_in, external_switch_event, thermal_event_n;
  wire ac_adapter_present, setup_switch_n, eject_in, dock_insert_n, hot_key_event_n;
  wire graphics_activity_n, panel_backlight_vee_in, battery_low_first_n, battery_low_last_n;
  wire [1:0] usb_overcurrent_n;
  wire [11:0] gpio_in, gpio_out, gpio_oe;
  wire bus_clock_halt_n, suspend_status_to_northbridge_n, clockgen_slow_request;
  wire apm_state_indicator_n, square_wave_out, clockgen_power_remove_n;
  wire power_remove_keep_dram, power_remove_keep_suspend, backlight_wave_out;
  wire display_on_out, contrast_out, ext_input_latch_strobe_n, ext_output_latch_strobe;
  wire [11:0] event_pulse;
  wire [13:0] general_input;
  wire [3:0] suspend_resume_event, standby_wake_event;
  wire force_suspend_req, vga_timer_reload, atx_supply;
  wire [19:0] evs = {standby_wake_event, suspend_resume_event, event_pulse};
  int total_checks = 0;
  int bad_count = 0;
  int pin_of[13] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 11, 12, 13, 14};
  int ev_of[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 11};
  logic [11:0] pat[2] = '{12'ha5a, 12'h5a5};

  always #2.5 clk = ~clk;
  pm_pin_signals_and_events i_dut (.*);
  pm_pins_far_side i_far (.*);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // counts pulses of one event line over eight cycles
  task automatic pulses(input int idx, input int exp);
    int n;
    n = 0;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      if (evs[idx] === 1'b1)
        n = n + 1;
    end
    chk(n, exp);
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    int a;
    int b;
    @(posedge clk);
    @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({bus_clock_halt_n, apm_state_indicator_n, ext_input_latch_strobe_n,
      event_pulse}, 15'h7000);
    cyc(4);
    chk(atx_supply, 1'b1);
    foreach (pat[i])
    begin
      @(posedge clk);
      general_output <= pat[i];
      cyc(2);
      chk({ext_output_latch_strobe, ext_input_latch_strobe_n, contrast_out, display_on_out,
        backlight_wave_out, power_remove_keep_suspend, power_remove_keep_dram,
        clockgen_power_remove_n, square_wave_out, apm_state_indicator_n, clockgen_slow_request,
        bus_clock_halt_n}, pat[i]);
    end
    @(posedge clk);
    out_func_sel <= 12'hfff;
    bus_clock_stop_req <= 1'b1;
    suspend_active <= 1'b1;
    slow_req <= 1'b1;
    halt_cycle <= 1'b1;
    power_remove_req <= 3'h7;
    sqw_select_1hz <= 1'b0;
    cyc(2);
    chk({bus_clock_halt_n, suspend_status_to_northbridge_n, clockgen_slow_request,
      apm_state_indicator_n, clockgen_power_remove_n, power_remove_keep_dram,
      power_remove_keep_suspend, backlight_wave_out,
      contrast_out}, 9'h04c);
    @(posedge clk);
    bus_clock_stop_req <= 1'b0;
    suspend_active <= 1'b0;
    slow_req <= 1'b0;
    halt_cycle <= 1'b0;
    stop_grant_cycle <= 1'b1;
    power_remove_req <= 3'h0;
    contrast_duty <= 8'hff;
    cyc(3);
    chk({bus_clock_halt_n, suspend_status_to_northbridge_n, clockgen_slow_request,
      apm_state_indicator_n, clockgen_power_remove_n, power_remove_keep_dram,
      power_remove_keep_suspend, contrast_out}, 8'hc9);
    @(posedge clk);
    stop_grant_cycle <= 1'b0;
    in_func_sel <= 14'h3fff;
    cyc(1);
    chk(general_input, 14'h0000);
    for (int i = 0; i < 13; i++)
    begin
      i_far.flip(pin_of[i]);
      pulses(ev_of[i], 1);
      i_far.flip(pin_of[i]);
      pulses(ev_of[i], (pin_of[i] == 4) ? 1 : 0);
    end
    @(posedge clk);
    in_func_sel <= 14'h0000;
    i_far.flip(5);
    pulses(4, 0);
    chk(general_input[5], 1'b0);
    i_far.flip(5);
    in_func_sel <= 14'h0002;
    i_far.flip(1);
    cyc(4);
    chk(force_suspend_req, 1'b1);
    @(posedge clk);
    in_func_sel <= 14'h0000;
    cyc(2);
    chk({force_suspend_req, general_input[1]}, 2'b01);
    i_far.flip(1);
    in_func_sel <= 14'h0600;
    vga_timer_mode <= 1'b1;
    i_far.flip(9);
    i_far.flip(10);
    cyc(4);
    chk({vga_timer_reload, event_pulse[8], display_on_out,
      backlight_wave_out}, 4'ha);
    @(posedge clk);
    display_invert <= 1'b1;
    i_far.flip(9);
    cyc(4);
    chk({vga_timer_reload, display_on_out}, 2'b00);
    @(posedge clk);
    backlight_wave_en <= 1'b1;
    cyc(2);
    chk(backlight_wave_out, 1'b1);
    @(posedge clk);
    backlight_duty <= 8'h00;
    cyc(2);
    chk(backlight_wave_out, 1'b0);
    @(posedge clk);
    backlight_duty <= 8'hff;
    i_far.flip(10);
    cyc(4);
    chk({backlight_wave_out, display_on_out}, 2'b01);
    @(posedge clk);
    in_strobe_req <= 1'b1;
    out_strobe_req <= 1'b1;
    @(posedge clk);
    in_strobe_req <= 1'b0;
    out_strobe_req <= 1'b0;
    a = 0;
    b = 0;
    repeat (10)
    begin
      cyc(1);
      a = a + (ext_input_latch_strobe_n === 1'b0);
      b = b + (ext_output_latch_strobe === 1'b1);
    end
    chk({a[7:0], b[7:0]}, 16'h0404);
    i_far.flip(15);
    pulses(16, 1);
    i_far.flip(23);
    pulses(12, 1);
    @(posedge clk);
    gpio_dir_out <= 12'hfff;
    gpio_out_val <= 12'hc3a;
    cyc(2);
    chk({gpio_oe, gpio_out}, 24'hfffc3a);
    @(posedge clk);
    gpio_dir_out <= 12'hf0f;
    battery_select_val <= 4'h6;
    battery_select_en <= 1'b1;
    cyc(2);
    chk({gpio_oe, gpio_out}, 24'hfffc6a);
    results;
  end
endmodule

bind pm_pin_signals_and_events pm_pins_chk i_chk (.*);
